//--- src/data_memory_pkg.sv
// Constants and types shared by the data memory address decode block
package data_memory_pkg;
	// Address map
	localparam logic [15:0] ROM_LAST = 16'h3FFF;
	localparam logic [15:0] RAM_BASE = 16'hFC80;
	localparam logic [15:0] MAIN_RAM_BASE = 16'hFE00;
	localparam logic [15:0] RAM_LAST = 16'hFEFF;
	localparam logic [15:0] SFR_BASE = 16'hFF00;
	localparam logic [15:0] SHORT_DIRECT_BASE = 16'hFE20;
	localparam logic [7:0] SFR_PAGE = 8'hFF;
	localparam logic [8:0] REG_FILE_PAGE = 9'h1FD; // FE80H upper nine bits
	localparam logic [15:0] PREFETCH_RESET_ADDR = 16'h0000;
	// Memory sizes in bytes and their index widths
	localparam int MAIN_RAM_BYTES = 256;
	localparam int PERIPH_RAM_BYTES = 384;
	localparam int MAIN_RAM_AW = 8;
	localparam int PERIPH_RAM_AW = 9;
	// Operand addressing modes from the execution unit
	typedef enum logic [1:0] {
		MODE_FULL = 2'b00,
		MODE_SHORT = 2'b01,
		MODE_SFR = 2'b10,
		MODE_GREG = 2'b11
	} addr_mode_t;
	// Decoded target of an address
	typedef enum logic [2:0] {
		REGION_MAIN_RAM = 3'b000,
		REGION_PERIPH_RAM = 3'b001,
		REGION_SFR = 3'b010,
		REGION_ROM = 3'b011,
		REGION_EXTERNAL = 3'b100
	} region_t;
	// Bus control states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RAM = 2'b10,
		ST_BUS = 2'b11
	} state_t;
endpackage

//--- src/byte_pair_ram.sv
// Byte-paired RAM: even and odd banks, word access reads both, registered read
`timescale 1ns/1ns
module byte_pair_ram #(
	parameter int AW = 8,
	parameter int BYTES = 256
) (
	input wire logic sys_clk,
	input wire logic en,
	input wire logic write,
	input wire logic word,
	input wire logic [AW-1:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata
);
	logic [7:0] even_bank [0:BYTES/2-1];
	logic [7:0] odd_bank [0:BYTES/2-1];
	logic [AW-2:0] row;

	assign row = addr[AW-1:1];

	// Word access pairs the even byte with the following odd byte
	always_ff @(posedge sys_clk) begin
		if (en) begin
			if (write) begin
				if (word || !addr[0]) begin
					even_bank[row] <= wdata[7:0];
				end
				if (word) begin
					odd_bank[row] <= wdata[15:8];
				end else if (addr[0]) begin
					odd_bank[row] <= wdata[7:0];
				end
			end
			if (word) begin
				rdata <= {odd_bank[row], even_bank[row]};
			end else begin
				rdata <= {8'h00, addr[0] ? odd_bank[row] : even_bank[row]};
			end
		end
	end
endmodule

//--- src/data_memory_address_decode.sv
// Data memory address decode, operand addressing and bus cycle control
`timescale 1ns/1ns
module data_memory_address_decode (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire data_memory_pkg::addr_mode_t req_mode,
	input wire logic [15:0] req_operand,
	input wire logic [3:0] req_reg_field,
	input wire logic req_word,
	input wire logic req_write,
	input wire logic [15:0] req_wdata,
	input wire logic [2:0] bank_select_flags,
	input wire logic register_set_select_flag,
	input wire logic external_access_pin,
	input wire logic queue_full,
	input wire logic fetch_restart,
	input wire logic [15:0] fetch_restart_addr,
	input wire logic bus_done,
	input wire logic [15:0] bus_rdata,
	output logic req_ready,
	output logic resp_done,
	output logic [15:0] resp_rdata,
	output logic bus_start,
	output logic bus_fetch,
	output logic [15:0] bus_addr,
	output data_memory_pkg::region_t bus_region,
	output logic bus_word,
	output logic bus_write,
	output logic [15:0] bus_wdata,
	output logic queue_load,
	output logic [7:0] queue_data
);
	import data_memory_pkg::*;

	state_t state, next_state;
	logic [15:0] cur_addr, next_cur_addr;
	region_t cur_region, next_cur_region;
	logic cur_word, next_cur_word;
	logic cur_write, next_cur_write;
	logic [15:0] cur_wdata, next_cur_wdata;
	logic [15:0] fetch_ptr, next_fetch_ptr;
	logic fetch_drop, next_fetch_drop;
	logic next_req_ready, next_resp_done, next_bus_start, next_bus_fetch;
	logic [15:0] next_resp_rdata, next_bus_addr, next_bus_wdata;
	region_t next_bus_region;
	logic next_bus_word, next_bus_write, next_queue_load;
	logic [7:0] next_queue_data;
	logic [15:0] req_addr;
	region_t req_region, fetch_region;
	logic main_en, periph_en, mem_write, mem_word;
	logic [15:0] mem_addr, mem_wdata, main_rdata, periph_rdata;
	logic [PERIPH_RAM_AW-1:0] periph_index;

	// Map a physical address to its target
	function automatic region_t region_of(input logic [15:0] a, input logic ea);
		if (a >= SFR_BASE) begin
			region_of = REGION_SFR;
		end else if (a >= MAIN_RAM_BASE) begin
			region_of = REGION_MAIN_RAM;
		end else if (a >= RAM_BASE) begin
			region_of = REGION_PERIPH_RAM;
		end else if (a <= ROM_LAST && ea) begin
			region_of = REGION_ROM;
		end else begin
			region_of = REGION_EXTERNAL;
		end
	endfunction

	// Operand to physical address for each addressing mode
	always_comb begin
		case (req_mode)
			MODE_SHORT: req_addr = SHORT_DIRECT_BASE + {8'h00, req_operand[7:0]};
			MODE_SFR: req_addr = {SFR_PAGE, req_operand[7:0]};
			MODE_GREG: begin
				// Set flag swaps the upper and lower half of the bank
				if (req_word) begin
					req_addr = {REG_FILE_PAGE, bank_select_flags,
						req_reg_field[2] ^ register_set_select_flag, req_reg_field[1:0], 1'b0};
				end else begin
					req_addr = {REG_FILE_PAGE, bank_select_flags,
						req_reg_field[3] ^ register_set_select_flag, req_reg_field[2:0]};
				end
			end
			default: req_addr = req_operand;
		endcase
	end

	assign req_region = region_of(req_addr, external_access_pin);
	assign fetch_region = region_of(fetch_ptr, external_access_pin);

	// RAM port steering: main RAM is hit on the accept cycle, peripheral RAM a cycle later
	always_comb begin
		main_en = 1'b0;
		periph_en = 1'b0;
		mem_addr = cur_addr;
		mem_word = cur_word;
		mem_write = cur_write;
		mem_wdata = cur_wdata;
		if (state == ST_IDLE && req_valid) begin
			mem_addr = req_addr;
			mem_word = req_word;
			mem_write = req_write;
			mem_wdata = req_wdata;
			main_en = (req_region == REGION_MAIN_RAM);
		end else if (state == ST_WAIT) begin
			periph_en = 1'b1;
		end
	end

	assign periph_index = 9'(mem_addr - RAM_BASE);

	// Sequencer: requests first, prefetch only while none is pending
	always_comb begin
		next_state = state;
		next_cur_addr = cur_addr;
		next_cur_region = cur_region;
		next_cur_word = cur_word;
		next_cur_write = cur_write;
		next_cur_wdata = cur_wdata;
		next_fetch_ptr = fetch_ptr;
		next_fetch_drop = fetch_drop;
		next_resp_done = 1'b0;
		next_resp_rdata = resp_rdata;
		next_bus_start = 1'b0;
		next_bus_fetch = bus_fetch;
		next_bus_addr = bus_addr;
		next_bus_region = bus_region;
		next_bus_word = bus_word;
		next_bus_write = bus_write;
		next_bus_wdata = bus_wdata;
		next_queue_load = 1'b0;
		next_queue_data = queue_data;
		case (state)
			ST_IDLE: begin
				if (req_valid) begin
					next_cur_addr = req_addr;
					next_cur_region = req_region;
					next_cur_word = req_word;
					next_cur_write = req_write;
					next_cur_wdata = req_wdata;
					if (req_region == REGION_MAIN_RAM) begin
						next_state = ST_RAM;
					end else if (req_region == REGION_PERIPH_RAM) begin
						next_state = ST_WAIT;
					end else begin
						next_state = ST_BUS;
						next_bus_start = 1'b1;
						next_bus_fetch = 1'b0;
						next_bus_addr = req_addr;
						next_bus_region = req_region;
						next_bus_word = req_word;
						next_bus_write = req_write;
						next_bus_wdata = req_wdata;
					end
				end else if (!queue_full && !fetch_restart) begin
					next_state = ST_BUS;
					next_fetch_drop = 1'b0;
					next_bus_start = 1'b1;
					next_bus_fetch = 1'b1;
					next_bus_addr = fetch_ptr;
					next_bus_region = fetch_region;
					next_bus_word = 1'b0;
					next_bus_write = 1'b0;
					next_bus_wdata = 16'h0000;
				end
			end
			ST_WAIT: next_state = ST_RAM;
			ST_RAM: begin
				next_state = ST_IDLE;
				next_resp_done = 1'b1;
				next_resp_rdata = (cur_region == REGION_MAIN_RAM) ? main_rdata : periph_rdata;
			end
			ST_BUS: begin
				if (bus_done) begin
					next_state = ST_IDLE;
					if (!bus_fetch) begin
						next_resp_done = 1'b1;
						next_resp_rdata = bus_rdata;
					end else if (!fetch_drop && !fetch_restart) begin
						next_queue_load = 1'b1;
						next_queue_data = bus_rdata[7:0];
						next_fetch_ptr = fetch_ptr + 16'h0001;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// A branch redirects prefetch and discards any fetch in flight
		if (fetch_restart) begin
			next_fetch_ptr = fetch_restart_addr;
			next_fetch_drop = (state == ST_BUS) && bus_fetch && !bus_done;
		end
	end

	assign next_req_ready = (next_state == ST_IDLE);

	// Register all state and outputs
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= ST_IDLE;
			cur_addr <= 16'h0000;
			cur_region <= REGION_EXTERNAL;
			cur_word <= 1'b0;
			cur_write <= 1'b0;
			cur_wdata <= 16'h0000;
			fetch_ptr <= PREFETCH_RESET_ADDR;
			fetch_drop <= 1'b0;
			req_ready <= 1'b1;
			resp_done <= 1'b0;
			resp_rdata <= 16'h0000;
			bus_start <= 1'b0;
			bus_fetch <= 1'b0;
			bus_addr <= 16'h0000;
			bus_region <= REGION_EXTERNAL;
			bus_word <= 1'b0;
			bus_write <= 1'b0;
			bus_wdata <= 16'h0000;
			queue_load <= 1'b0;
			queue_data <= 8'h00;
		end else begin
			state <= next_state;
			cur_addr <= next_cur_addr;
			cur_region <= next_cur_region;
			cur_word <= next_cur_word;
			cur_write <= next_cur_write;
			cur_wdata <= next_cur_wdata;
			fetch_ptr <= next_fetch_ptr;
			fetch_drop <= next_fetch_drop;
			req_ready <= next_req_ready;
			resp_done <= next_resp_done;
			resp_rdata <= next_resp_rdata;
			bus_start <= next_bus_start;
			bus_fetch <= next_bus_fetch;
			bus_addr <= next_bus_addr;
			bus_region <= next_bus_region;
			bus_word <= next_bus_word;
			bus_write <= next_bus_write;
			bus_wdata <= next_bus_wdata;
			queue_load <= next_queue_load;
			queue_data <= next_queue_data;
		end
	end

	// Main RAM FE00H-FEFFH, also holds the general register banks
	byte_pair_ram #(.AW(MAIN_RAM_AW), .BYTES(MAIN_RAM_BYTES)) main_ram (
		.sys_clk(sys_clk),
		.en(main_en),
		.write(mem_write),
		.word(mem_word),
		.addr(mem_addr[MAIN_RAM_AW-1:0]),
		.wdata(mem_wdata),
		.rdata(main_rdata)
	);

	// Peripheral RAM FC80H-FDFFH
	byte_pair_ram #(.AW(PERIPH_RAM_AW), .BYTES(PERIPH_RAM_BYTES)) periph_ram (
		.sys_clk(sys_clk),
		.en(periph_en),
		.write(mem_write),
		.word(mem_word),
		.addr(periph_index),
		.wdata(mem_wdata),
		.rdata(periph_rdata)
	);
endmodule

//--- dv/data_memory_address_decode_props.sv
// Port assertions for the data memory address decode block
`timescale 1ns/1ns
module dmad_props (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire data_memory_pkg::addr_mode_t req_mode,
	input wire logic [15:0] req_operand,
	input wire logic req_word,
	input wire logic external_access_pin,
	input wire logic fetch_restart,
	input wire logic bus_done,
	input wire logic [15:0] bus_rdata,
	input wire logic req_ready,
	input wire logic resp_done,
	input wire logic bus_start,
	input wire logic bus_fetch,
	input wire logic [15:0] bus_addr,
	input wire data_memory_pkg::region_t bus_region,
	input wire logic bus_word,
	input wire logic queue_load,
	input wire logic [7:0] queue_data
);
	import data_memory_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Taken requests, split by mode
	wire take = req_valid && req_ready;
	wire full = take && req_mode == MODE_FULL;
	wire [15:0] op = req_operand;
	// Restart seen since the last bus start; restart wins so a drop on the start edge is kept
	logic restarted;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			restarted <= 1'b0;
		end else if (fetch_restart) begin
			restarted <= 1'b1;
		end else if (bus_start) begin
			restarted <= 1'b0;
		end
	end
	a_main_ram_time: assert property (full && op[15:8] == 8'hFE |=> !resp_done ##1 resp_done)
		else $error("main RAM answer time");
	a_periph_ram_time: assert property (full && op >= 16'hFC80 && op < 16'hFE00 |=> !resp_done [*2] ##1 resp_done)
		else $error("peripheral RAM answer time");
	a_sfr_page_addr: assert property (take && req_mode == MODE_SFR |=> bus_start && bus_region == REGION_SFR
		&& bus_addr == {8'hFF, $past(op[7:0])} && bus_word == $past(req_word))
		else $error("special register address");
	a_short_high_addr: assert property (take && req_mode == MODE_SHORT && op[7:0] >= 8'hE0
		|=> bus_start && bus_addr == 16'hFE20 + {8'h00, $past(op[7:0])})
		else $error("short direct address");
	a_full_sfr_route: assert property (full && op[15:8] == 8'hFF |=> bus_start && bus_region == REGION_SFR)
		else $error("special register route");
	a_rom_pin_route: assert property (full && op <= 16'h3FFF |=> bus_start
		&& bus_region == ($past(external_access_pin) ? REGION_ROM : REGION_EXTERNAL))
		else $error("ROM region route");
	a_unmapped_ext: assert property (full && op > 16'h3FFF && op < 16'hFC80 |=> bus_region == REGION_EXTERNAL)
		else $error("unmapped not external");
	a_bus_answer: assert property (bus_done && !bus_fetch |=> resp_done)
		else $error("bus answer lost");
	a_fetch_load: assert property (bus_done && bus_fetch && !fetch_restart && !restarted
		|=> queue_load && queue_data == $past(bus_rdata[7:0]))
		else $error("fetched byte not queued");
	c_greg: cover property (take && req_mode == MODE_GREG);
	c_short_word: cover property (take && req_mode == MODE_SHORT && req_word);
	c_queue: cover property (queue_load);
endmodule
bind data_memory_address_decode dmad_props u_props (.sys_clk, .reset, .req_valid, .req_mode, .req_operand,
	.req_word, .external_access_pin, .fetch_restart, .bus_done, .bus_rdata, .req_ready, .resp_done, .bus_start,
	.bus_fetch, .bus_addr, .bus_region, .bus_word, .queue_load, .queue_data);

//--- dv/bus_answer.sv
// Far-side bus responder: answers each bus cycle after a short or long wait
`timescale 1ns/1ns
module bus_answer (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic bus_start,
	input wire logic [15:0] bus_addr,
	output logic bus_done,
	output logic [15:0] bus_rdata
);
	logic busy;
	logic [2:0] left;
	// Data churns outside the done cycle so stale values are never trusted
	always_ff @(posedge sys_clk) begin
		bus_done <= 1'b0;
		bus_rdata <= bus_rdata + 16'h1357;
		if (reset) begin
			busy <= 1'b0;
			bus_rdata <= 16'h0000;
		end else if (bus_start) begin
			busy <= 1'b1;
			left <= slow ? 3'h4 : 3'h0;
		end else if (busy && left == 3'h0) begin
			busy <= 1'b0;
			bus_done <= 1'b1;
			bus_rdata <= bus_addr ^ 16'hA5C3;
		end else if (busy) begin
			left <= left - 3'h1;
		end
	end
endmodule

//--- dv/data_memory_address_decode_tb.sv
// Bench for the data memory address decode block
`timescale 1ns/1ns
module data_memory_address_decode_tb;
	import data_memory_pkg::*;
	logic sys_clk = 0, reset = 1, req_valid = 0, req_word = 0, req_write = 0, slow = 0, fetch_restart = 0;
	logic register_set_select_flag = 0, external_access_pin = 1, queue_full = 1, w, s;
	logic bus_done, req_ready, resp_done, bus_start, bus_fetch, bus_word, bus_write, queue_load;
	addr_mode_t req_mode = MODE_FULL;
	region_t bus_region, sr;
	logic [15:0] req_operand = 0, req_wdata = 0, fetch_restart_addr = 0, bus_rdata, resp_rdata, bus_addr;
	logic [15:0] bus_wdata, a, d, sa;
	logic [16:0] sw;
	logic [3:0] req_reg_field = 0, f;
	logic [2:0] bank_select_flags = 0, b;
	logic [7:0] queue_data;
	int fail_count = 0, checks_done = 0, n, i;
	always #5 sys_clk = ~sys_clk;
	data_memory_address_decode u_dut (.sys_clk, .reset, .req_valid, .req_mode, .req_operand, .req_reg_field,
		.req_word, .req_write, .req_wdata, .bank_select_flags, .register_set_select_flag, .external_access_pin,
		.queue_full, .fetch_restart, .fetch_restart_addr, .bus_done, .bus_rdata, .req_ready, .resp_done,
		.resp_rdata, .bus_start, .bus_fetch, .bus_addr, .bus_region, .bus_word, .bus_write, .bus_wdata,
		.queue_load, .queue_data);
	bus_answer u_far (.sys_clk, .reset, .slow, .bus_start, .bus_addr, .bus_done, .bus_rdata);
	task chk(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// General register address: bank of sixteen bytes above FE80H, set flag swaps the halves
	function automatic logic [15:0] greg_addr(input logic [2:0] bank, input logic swap, input logic [3:0] fld,
		input logic wd);
		greg_addr = 16'hFE80 + {bank, 4'h0} + (wd ? {fld[2] ^ swap, fld[1:0], 1'b0} : {fld[3] ^ swap, fld[2:0]});
	endfunction
	// Read data the far side hands back for a bus address
	function automatic logic [15:0] far_data(input logic [15:0] x);
		far_data = x ^ 16'hA5C3;
	endfunction
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task hang_check;
		if (n == 40) begin
			fail_count++;
			summarize;
		end
	endtask
	// Request held until taken; n ends one below the cycles to the answer
	task acc(input addr_mode_t m, input logic [15:0] op, input logic wo, wr);
		@(posedge sys_clk);
		req_valid <= 1;
		req_mode <= m;
		req_operand <= op;
		req_word <= wo;
		req_write <= wr;
		req_wdata <= d;
		@(negedge sys_clk);
		for (n = 0; n < 40 && !req_ready; n++) @(negedge sys_clk);
		hang_check;
		@(posedge sys_clk);
		req_valid <= 0;
		for (n = 0; n < 40; n++) begin
			@(negedge sys_clk);
			if (bus_start) begin
				sa = bus_addr;
				sr = bus_region;
				sw = {bus_write, bus_wdata};
			end
			if (resp_done) break;
		end
		hang_check;
	endtask
	initial begin
		n = $urandom(1);
		repeat (2) @(posedge sys_clk);
		reset <= 0;
		// RAM words, main and peripheral alternating, even addresses only
		for (i = 0; i < 6; i++) begin
			a = i[0] ? 16'hFC80 + {7'h0, 8'($urandom % 192), 1'b0} : {8'hFE, 7'($urandom), 1'b0};
			d = 16'($urandom);
			acc(MODE_FULL, a, 1, 1);
			acc(MODE_FULL, a, 1, 0);
			chk(resp_rdata, d);
			chk(16'(n), i[0] ? 16'h2 : 16'h1);
		end
		$display("ram test end");
		d = 16'($urandom);
		a = {8'h00, 7'($urandom % 112), 1'b0};
		acc(MODE_SHORT, a, 1, 1);
		acc(MODE_FULL, 16'hFE20 + a, 1, 0);
		chk(resp_rdata, d);
		acc(MODE_FULL, 16'hFE21 + a, 0, 0);
		chk(resp_rdata, {8'h00, d[15:8]});
		a = {8'h00, 3'h7, 4'($urandom), 1'b0};
		acc(MODE_SHORT, a, 1, 0);
		chk(sa, 16'hFE20 + a);
		chk(resp_rdata, far_data(16'hFE20 + a));
		a = {8'h00, 7'($urandom), 1'b0};
		acc(MODE_SFR, a, 1, 0);
		chk(sa, {8'hFF, a[7:0]});
		chk(resp_rdata, far_data({8'hFF, a[7:0]}));
		d = 16'($urandom);
		acc(MODE_SFR, a, 1, 1);
		chk(sw[15:0], d);
		chk({15'h0, sw[16]}, 16'h0001);
		$display("short and sfr test end");
		// Banked registers written by field, read back by full address
		for (i = 0; i < 4; i++) begin
			{b, s, f, w} = 9'($urandom);
			d = 16'($urandom);
			@(posedge sys_clk);
			bank_select_flags <= b;
			register_set_select_flag <= s;
			req_reg_field <= f;
			acc(MODE_GREG, 16'h0000, w, 1);
			a = greg_addr(b, s, f, w);
			acc(MODE_FULL, a, w, 0);
			chk(resp_rdata, w ? d : {8'h00, d[7:0]});
		end
		$display("register test end");
		// Last pass reaches the special registers by full address
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			external_access_pin <= i != 1;
			slow <= i[0];
			a = i == 2 ? 16'h4000 + 16'($urandom % 16'hBC80) : {2'b00, 14'($urandom)};
			if (i == 3) begin
				a = {8'hFF, 8'($urandom)};
			end
			acc(MODE_FULL, a, 0, 0);
			sr = i == 0 ? REGION_ROM : i == 3 ? REGION_SFR : sr;
			chk({13'h0, sr}, {13'h0, i == 0 ? REGION_ROM : i == 3 ? REGION_SFR : REGION_EXTERNAL});
			chk(resp_rdata, far_data(a));
		end
		$display("region test end");
		// Prefetch from a restarted pointer while no request is pending
		@(posedge sys_clk);
		external_access_pin <= 1;
		fetch_restart <= 1;
		fetch_restart_addr <= 16'h0040;
		queue_full <= 0;
		@(posedge sys_clk);
		fetch_restart <= 0;
		for (i = 0; i < 2; i++) begin
			for (n = 0; n < 40; n++) begin
				@(negedge sys_clk);
				if (queue_load) break;
			end
			hang_check;
			chk({8'h00, queue_data}, {8'h00, (8'h40 + 8'(i)) ^ 8'hC3});
		end
		$display("prefetch test end");
		summarize;
	end
endmodule
